// *** src/pcsp_defines.vh ***
`ifndef PCSP_DEFINES_VH
`define PCSP_DEFINES_VH

// word size and bit counters
`define PCSP_WORD_BITS 8
`define PCSP_LAST_FALL 4'h8
`define PCSP_LAST_RX_BIT 3'h7

// code sent when the user side has no word ready at slot start
`define PCSP_IDLE_CODE 8'hff

// falling edges skipped after the link sync before the second bearer slot
`define PCSP_SLOT2_SKIP 4'ha

// one-hot engine states
`define PCSP_ST_IDLE 3'b001
`define PCSP_ST_ARMED 3'b010
`define PCSP_ST_SHIFT 3'b100

// positions in the synchronised pin vector
`define PCSP_PIN_COUNT 11
`define PCSP_P_ISDN 10
`define PCSP_P_LONG 9
`define PCSP_P_SLOT2 8
`define PCSP_P_TXCLK 7
`define PCSP_P_TXFS 6
`define PCSP_P_RXCLK 5
`define PCSP_P_RXFS 4
`define PCSP_P_RXIN 3
`define PCSP_P_LKCLK 2
`define PCSP_P_LKFS 1
`define PCSP_P_LKRX 0

`endif

// *** src/pcsp_sync2.v ***
`timescale 1ns/1ns
// two-stage synchroniser for a vector of asynchronous pins
module pcsp_sync2 #(
    parameter WIDTH = 1
) (
    input wire ref_clk,
    input wire rstn,
    input wire [WIDTH-1:0] asyncIn,
    output reg [WIDTH-1:0] syncOut
);
    reg [WIDTH-1:0] meta_reg;

    // the first stage feeds only the second stage
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            meta_reg <= {WIDTH{1'b0}};
            syncOut <= {WIDTH{1'b0}};
        end else begin
            meta_reg <= asyncIn;
            syncOut <= meta_reg;
        end
    end
endmodule // pcsp_sync2

// *** src/pcsp_fifo2.v ***
`timescale 1ns/1ns
// small fifo with registered valid and ready, so a stalled reader loses no word
module pcsp_fifo2 #(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW = 1
) (
    input wire ref_clk,
    input wire rstn,
    input wire [WIDTH-1:0] inData,
    input wire inValid,
    output reg inReady,
    output wire [WIDTH-1:0] outData,
    output reg outValid,
    input wire outReady
);
    localparam [AW-1:0] LAST_PTR = DEPTH[AW-1:0] - 1'b1;
    localparam [AW:0] FULL_COUNT = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_reg;
    reg [AW-1:0] rdPtr_reg;
    reg [AW:0] count_reg;
    reg [AW:0] count_next;
    wire doWrite = inValid && inReady;
    wire doRead = outValid && outReady;

    wire [AW-1:0] rdPtr_next = !doRead ? rdPtr_reg
        : (rdPtr_reg == LAST_PTR) ? {AW{1'b0}} : rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
    reg [WIDTH-1:0] headWord_reg;
    reg [WIDTH-1:0] headWord_next;

    // head word kept in a flop so the read port never comes through the array mux
    always @* begin
        headWord_next = mem[rdPtr_next];
        if (doWrite && wrPtr_reg == rdPtr_next) begin
            headWord_next = inData; // a word written into an empty head passes through
        end
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            headWord_reg <= {WIDTH{1'b0}};
        end else begin
            headWord_reg <= headWord_next;
        end
    end

    assign outData = headWord_reg;

    // occupancy after this cycle's write and read
    always @* begin
        count_next = count_reg;
        if (doWrite && !doRead) begin
            count_next = count_reg + {{AW{1'b0}}, 1'b1};
        end else if (doRead && !doWrite) begin
            count_next = count_reg - {{AW{1'b0}}, 1'b1};
        end
    end

    // pointers and flags; flags are registered so the ports come from flops
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wrPtr_reg <= {AW{1'b0}};
            rdPtr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
            inReady <= 1'b0;
            outValid <= 1'b0;
        end else begin
            if (doWrite) begin
                wrPtr_reg <= (wrPtr_reg == LAST_PTR) ? {AW{1'b0}} : wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            if (doRead) begin
                rdPtr_reg <= (rdPtr_reg == LAST_PTR) ? {AW{1'b0}} : rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
            end
            count_reg <= count_next;
            inReady <= (count_next != FULL_COUNT);
            outValid <= (count_next != {(AW+1){1'b0}});
        end
    end

    // storage needs no reset
    always @(posedge ref_clk) begin
        if (doWrite) begin
            mem[wrPtr_reg] <= inData;
        end
    end
endmodule // pcsp_fifo2

// *** src/pcsp_serial_port.v ***
`timescale 1ns/1ns
`include "pcsp_defines.vh"
module pcsp_serial_port #(
    parameter WORD_BITS = `PCSP_WORD_BITS,
    parameter RX_DEPTH = 2
) (
    input wire ref_clk,
    input wire rstn,
    input wire isdnFourWireMode,
    input wire longFrameMode,
    input wire secondBearerSlot,
    input wire txBitClock,
    input wire txFrameSync,
    output reg txPcmOut,
    output reg txPcmOutEn,
    input wire rxBitClock,
    input wire rxFrameSync,
    input wire rxPcmIn,
    input wire linkBitClock,
    input wire linkFrameSync,
    input wire linkRxData,
    output reg linkTxData,
    output reg linkTxDataEn,
    input wire [WORD_BITS-1:0] txWord,
    input wire txWordValid,
    output reg txWordReady,
    output reg txUnderrun,
    output wire [WORD_BITS-1:0] rxWord,
    output wire rxWordValid,
    input wire rxWordReady,
    output reg rxOverrun
);
    wire [`PCSP_PIN_COUNT-1:0] pins;
    reg [2:0] clkPrev_reg;

    // every pin crosses two flops before any logic looks at it
    pcsp_sync2 #(
        .WIDTH(`PCSP_PIN_COUNT)
    ) pinSync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .asyncIn({isdnFourWireMode, longFrameMode, secondBearerSlot, txBitClock,
                  txFrameSync, rxBitClock, rxFrameSync, rxPcmIn, linkBitClock,
                  linkFrameSync, linkRxData}),
        .syncOut(pins)
    );

    wire isdnMode = pins[`PCSP_P_ISDN];
    wire longMode = pins[`PCSP_P_LONG] && !isdnMode;
    wire slot2 = pins[`PCSP_P_SLOT2];
    wire [3:0] slotSkip = (isdnMode && slot2) ? `PCSP_SLOT2_SKIP : 4'h0;

    // edge detection runs on the synchronised copies only
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clkPrev_reg <= 3'h0;
        end else begin
            clkPrev_reg <= {pins[`PCSP_P_TXCLK], pins[`PCSP_P_RXCLK], pins[`PCSP_P_LKCLK]};
        end
    end

    // in link mode both directions share the link clock and sync
    wire txClk = isdnMode ? pins[`PCSP_P_LKCLK] : pins[`PCSP_P_TXCLK];
    wire txClkPrev = isdnMode ? clkPrev_reg[0] : clkPrev_reg[2];
    wire rxClk = isdnMode ? pins[`PCSP_P_LKCLK] : pins[`PCSP_P_RXCLK];
    wire rxClkPrev = isdnMode ? clkPrev_reg[0] : clkPrev_reg[1];
    wire txFs = isdnMode ? pins[`PCSP_P_LKFS] : pins[`PCSP_P_TXFS];
    wire rxFs = isdnMode ? pins[`PCSP_P_LKFS] : pins[`PCSP_P_RXFS];
    wire rxBit = isdnMode ? pins[`PCSP_P_LKRX] : pins[`PCSP_P_RXIN];
    wire txRise = txClk && !txClkPrev;
    wire txFall = !txClk && txClkPrev;
    wire rxFall = !rxClk && rxClkPrev;

    // ---------------- transmit word holding register ----------------
    reg [WORD_BITS-1:0] txHold_reg;
    reg txHoldFull_reg;
    reg txLoad;
    wire txAccept = txWordValid && txWordReady;

    // a word accepted in the cycle the slot consumes one is kept, not lost
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txHold_reg <= `PCSP_IDLE_CODE;
            txHoldFull_reg <= 1'b0;
            txWordReady <= 1'b0;
            txUnderrun <= 1'b0;
        end else begin
            if (txAccept) begin
                txHold_reg <= txWord;
            end
            if (txAccept) begin
                txHoldFull_reg <= 1'b1;
            end else if (txLoad) begin
                txHoldFull_reg <= 1'b0;
            end
            txWordReady <= !(txAccept || (txHoldFull_reg && !txLoad));
            txUnderrun <= txLoad && !txHoldFull_reg;
        end
    end

    wire [WORD_BITS-1:0] txSource = txHoldFull_reg ? txHold_reg : `PCSP_IDLE_CODE;

    // ---------------- transmit engine ----------------
    reg [2:0] txState_reg;
    reg [WORD_BITS-1:0] txShift_reg;
    reg [3:0] txFalls_reg;
    reg [3:0] txSkip_reg;
    reg txDone_reg;
    reg txBit_reg;
    reg txEn_reg;

    // slot start loads the word; a late start in long frame is still clean
    always @* begin
        txLoad = 1'b0;
        case (txState_reg)
            `PCSP_ST_IDLE: txLoad = longMode && txFs && txClk && !txDone_reg;
            `PCSP_ST_ARMED: txLoad = txRise && (txSkip_reg == 4'h0);
            default: txLoad = 1'b0;
        endcase
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txState_reg <= `PCSP_ST_IDLE;
            txShift_reg <= `PCSP_IDLE_CODE;
            txFalls_reg <= 4'h0;
            txSkip_reg <= 4'h0;
            txDone_reg <= 1'b0;
            txBit_reg <= 1'b0;
            txEn_reg <= 1'b0;
        end else begin
            if (!txFs) begin
                txDone_reg <= 1'b0; // one word per long-frame sync pulse
            end
            case (txState_reg)
                `PCSP_ST_IDLE: begin
                    txEn_reg <= 1'b0;
                    if (txLoad) begin
                        txShift_reg <= {txSource[WORD_BITS-2:0], 1'b0};
                        txBit_reg <= txSource[WORD_BITS-1];
                        txEn_reg <= 1'b1;
                        txFalls_reg <= 4'h0;
                        txState_reg <= `PCSP_ST_SHIFT;
                    end else if (!longMode && txFall && txFs) begin
                        txSkip_reg <= slotSkip;
                        txState_reg <= `PCSP_ST_ARMED;
                    end
                end
                `PCSP_ST_ARMED: begin
                    if (txLoad) begin
                        txShift_reg <= {txSource[WORD_BITS-2:0], 1'b0};
                        txBit_reg <= txSource[WORD_BITS-1];
                        txEn_reg <= 1'b1;
                        txFalls_reg <= 4'h0;
                        txState_reg <= `PCSP_ST_SHIFT;
                    end else if (txFall && txSkip_reg != 4'h0) begin
                        txSkip_reg <= txSkip_reg - 4'h1;
                    end
                end
                `PCSP_ST_SHIFT: begin
                    if (txRise && txFalls_reg != `PCSP_LAST_FALL) begin
                        txBit_reg <= txShift_reg[WORD_BITS-1];
                        txShift_reg <= {txShift_reg[WORD_BITS-2:0], 1'b0};
                    end
                    if (txFall && txFalls_reg != `PCSP_LAST_FALL) begin
                        txFalls_reg <= txFalls_reg + 4'h1;
                    end
                    // release after the eighth fall; long frame also waits for sync low
                    if ((txFall && txFalls_reg == `PCSP_LAST_FALL - 4'h1 && !(longMode && txFs))
                        || (txFalls_reg == `PCSP_LAST_FALL && !(longMode && txFs))) begin
                        txEn_reg <= 1'b0;
                        txDone_reg <= longMode;
                        txState_reg <= `PCSP_ST_IDLE;
                    end
                end
                default: begin
                    txEn_reg <= 1'b0;
                    txState_reg <= `PCSP_ST_IDLE;
                end
            endcase
        end
    end

    // route the engine to the pin of the active mode; the other stays released
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            txPcmOut <= 1'b0;
            txPcmOutEn <= 1'b0;
            linkTxData <= 1'b0;
            linkTxDataEn <= 1'b0;
        end else begin
            txPcmOut <= txBit_reg;
            linkTxData <= txBit_reg;
            txPcmOutEn <= txEn_reg && !isdnMode;
            linkTxDataEn <= txEn_reg && isdnMode;
        end
    end

    // ---------------- receive engine ----------------
    reg [2:0] rxState_reg;
    reg [WORD_BITS-1:0] rxShift_reg;
    reg [2:0] rxCount_reg;
    reg [3:0] rxSkip_reg;
    reg rxDone_reg;
    reg [WORD_BITS-1:0] rxPend_reg;
    reg rxPendValid_reg;
    reg rxComplete;
    reg [WORD_BITS-1:0] rxWordNext;
    wire rxBufReady;
    wire rxPop = rxPendValid_reg && rxBufReady;

    // the word whose last bit falls now, shifted in msb first
    always @* begin
        rxWordNext = {rxShift_reg[WORD_BITS-2:0], rxBit};
        rxComplete = (rxState_reg == `PCSP_ST_SHIFT) && rxFall
            && (rxCount_reg == `PCSP_LAST_RX_BIT);
    end

    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxState_reg <= `PCSP_ST_IDLE;
            rxShift_reg <= {WORD_BITS{1'b0}};
            rxCount_reg <= 3'h0;
            rxSkip_reg <= 4'h0;
            rxDone_reg <= 1'b0;
        end else begin
            if (!rxFs) begin
                rxDone_reg <= 1'b0;
            end
            case (rxState_reg)
                `PCSP_ST_IDLE: begin
                    if (rxFall && rxFs && longMode && !rxDone_reg) begin
                        rxShift_reg <= {{(WORD_BITS-1){1'b0}}, rxBit};
                        rxCount_reg <= 3'h1;
                        rxState_reg <= `PCSP_ST_SHIFT;
                    end else if (rxFall && rxFs && !longMode) begin
                        rxSkip_reg <= slotSkip;
                        rxState_reg <= `PCSP_ST_ARMED;
                    end
                end
                `PCSP_ST_ARMED: begin
                    if (rxFall && rxSkip_reg != 4'h0) begin
                        rxSkip_reg <= rxSkip_reg - 4'h1;
                    end else if (rxFall) begin
                        rxShift_reg <= {{(WORD_BITS-1){1'b0}}, rxBit};
                        rxCount_reg <= 3'h1;
                        rxState_reg <= `PCSP_ST_SHIFT;
                    end
                end
                `PCSP_ST_SHIFT: begin
                    if (rxFall) begin
                        rxShift_reg <= rxWordNext;
                        rxCount_reg <= rxCount_reg + 3'h1;
                    end
                    if (rxComplete) begin
                        rxDone_reg <= longMode;
                        rxState_reg <= `PCSP_ST_IDLE;
                    end
                end
                default: begin
                    rxState_reg <= `PCSP_ST_IDLE;
                end
            endcase
        end
    end

    // one-word stage ahead of the fifo; overrun only when both are blocked
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rxPend_reg <= {WORD_BITS{1'b0}};
            rxPendValid_reg <= 1'b0;
            rxOverrun <= 1'b0;
        end else begin
            rxOverrun <= rxComplete && rxPendValid_reg && !rxBufReady;
            if (rxComplete && (!rxPendValid_reg || rxBufReady)) begin
                rxPend_reg <= rxWordNext;
                rxPendValid_reg <= 1'b1;
            end else if (rxPop) begin
                rxPendValid_reg <= 1'b0;
            end
        end
    end

    pcsp_fifo2 #(
        .WIDTH(WORD_BITS),
        .DEPTH(RX_DEPTH),
        .AW(1)
    ) rxFifo (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .inData(rxPend_reg),
        .inValid(rxPendValid_reg),
        .inReady(rxBufReady),
        .outData(rxWord),
        .outValid(rxWordValid),
        .outReady(rxWordReady)
    );
endmodule // pcsp_serial_port

// *** verification/pcsp_serial_port_monitor.sv ***
`timescale 1ns/1ns
// watches the tx and link pins against the bit clock edges that must cause them
module pcsp_serial_port_monitor #(
    parameter WORD_BITS = 8
) (
    input wire ref_clk,
    input wire rstn,
    input wire isdnFourWireMode,
    input wire txBitClock,
    input wire txPcmOut,
    input wire txPcmOutEn,
    input wire linkBitClock,
    input wire linkTxData,
    input wire linkTxDataEn,
    input wire txWordValid,
    input wire txWordReady,
    input wire [WORD_BITS-1:0] rxWord,
    input wire rxWordValid,
    input wire rxWordReady
);
    reg txClkReg;
    reg lkClkReg;
    reg [3:0] txRiseAge;
    reg [3:0] txFallAge;
    reg [3:0] lkRiseAge;
    reg [3:0] lkFallAge;

    // cycles since each raw clock edge; saturating so long idle gaps cannot wrap
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            {txClkReg, lkClkReg} <= 2'h0;
            {txRiseAge, txFallAge, lkRiseAge, lkFallAge} <= 16'hffff;
        end else begin
            txClkReg <= txBitClock;
            lkClkReg <= linkBitClock;
            txRiseAge <= (txBitClock && !txClkReg) ? 4'h0 : txRiseAge + {3'h0, txRiseAge != 4'hf};
            txFallAge <= (!txBitClock && txClkReg) ? 4'h0 : txFallAge + {3'h0, txFallAge != 4'hf};
            lkRiseAge <= (linkBitClock && !lkClkReg) ? 4'h0 : lkRiseAge + {3'h0, lkRiseAge != 4'hf};
            lkFallAge <= (!linkBitClock && lkClkReg) ? 4'h0 : lkFallAge + {3'h0, lkFallAge != 4'hf};
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // the pin path allows 3..4 edges, the range leaves two slack edges each side
    sequence sTxStart; $rose(txPcmOutEn); endsequence
    sequence sTxShift; txPcmOutEn && $past(txPcmOutEn) && $changed(txPcmOut); endsequence
    sequence sAccept; txWordValid && txWordReady; endsequence
    sequence sLinkShift; linkTxDataEn && $past(linkTxDataEn) && $changed(linkTxData); endsequence
    sequence sRxStall; rxWordValid && !rxWordReady; endsequence

    chk_tx_drive_start: assert property (sTxStart |-> txRiseAge inside {[1:6]})
        else $error("tx enable rose without a recent bit clock rise");
    chk_tx_bit_step: assert property (sTxShift |-> txRiseAge inside {[1:6]})
        else $error("tx bit changed away from a bit clock rise");
    chk_tx_release: assert property ($fell(txPcmOutEn) |-> txFallAge inside {[1:6]})
        else $error("tx release not tied to a bit clock fall");
    chk_link_start: assert property ($rose(linkTxDataEn) |-> lkRiseAge inside {[1:6]})
        else $error("link drive began away from a link clock rise");
    chk_link_step: assert property (sLinkShift |-> lkRiseAge inside {[1:6]})
        else $error("link bit changed away from a link clock rise");
    chk_link_release: assert property ($fell(linkTxDataEn) |-> lkFallAge inside {[1:6]})
        else $error("link release not tied to a link clock fall");
    chk_tx_mode_quiet: assert property (isdnFourWireMode [*8] |=> !txPcmOutEn)
        else $error("tx pin driven in link mode");
    chk_link_mode_quiet: assert property (!isdnFourWireMode [*8] |=> !linkTxDataEn)
        else $error("link pin driven outside link mode");
    chk_hold_accept: assert property (sAccept |=> !txWordReady)
        else $error("hold register took a second word");
    chk_rx_word_hold: assert property (sRxStall |=> rxWordValid && $stable(rxWord))
        else $error("received word lost while reader stalled");
endmodule // pcsp_serial_port_monitor

bind pcsp_serial_port pcsp_serial_port_monitor #(.WORD_BITS(WORD_BITS)) mon (.ref_clk, .rstn,
    .isdnFourWireMode, .txBitClock, .txPcmOut, .txPcmOutEn, .linkBitClock, .linkTxData,
    .linkTxDataEn, .txWordValid, .txWordReady, .rxWord, .rxWordValid, .rxWordReady);

// *** verification/pcsp_highway_model.sv ***
`timescale 1ns/1ns
// highway master: bit clocks and syncs run only inside frames
module pcsp_highway_model (
    input wire isdnFourWireMode,
    input wire longFrameMode,
    input wire secondBearerSlot,
    input wire txPcmOut,
    input wire txPcmOutEn,
    input wire linkTxData,
    input wire linkTxDataEn,
    output wire txBitClock,
    output wire txFrameSync,
    output wire rxBitClock,
    output wire rxFrameSync,
    output wire rxPcmIn,
    output wire linkBitClock,
    output wire linkFrameSync,
    output wire linkRxData
);
    reg clk = 1'b0;
    reg fs = 1'b0;
    reg dat = 1'b0;
    reg started = 1'b0;
    time lastStart = 0;
    wire txLine = isdnFourWireMode ? (linkTxDataEn ? linkTxData : 1'bz)
                                   : (txPcmOutEn ? txPcmOut : 1'bz);

    // the unused clock and sync pins stay low so they cannot start a stray frame; both data pins follow dat
    assign txBitClock = clk & !isdnFourWireMode;
    assign rxBitClock = txBitClock;
    assign txFrameSync = fs & !isdnFourWireMode;
    assign rxFrameSync = txFrameSync;
    assign linkBitClock = clk & isdnFourWireMode;
    assign linkFrameSync = fs & isdnFourWireMode;
    assign rxPcmIn = dat;
    assign linkRxData = dat;

    // one frame at 125 ns a bit; a released tx line samples as z and fails
    task frame(input [7:0] rxw, output [7:0] txw);
        integer k;
        integer off;
        begin
            if (isdnFourWireMode && started && $time < lastStart + 125000)
                #(lastStart + 125000 - $time);
            lastStart = $time;
            started = 1'b1;
            off = (isdnFourWireMode && secondBearerSlot) ? 10 : 0;
            txw = 8'h00;
            if (!longFrameMode || isdnFourWireMode) begin
                fs = 1'b1;
                #20 clk = 1'b1;
                #62 clk = 1'b0;
                #30 fs = 1'b0;
                #33;
            end
            for (k = 1; k <= off + 8; k = k + 1) begin
                clk = 1'b1;
                if (longFrameMode && !isdnFourWireMode && k == 1) fs = 1'b1;
                dat = (k > off) ? rxw[off + 8 - k] : ~dat;
                #63 if (k > off) txw[off + 8 - k] = txLine;
                clk = 1'b0;
                #30 if (k == 2) fs = 1'b0;
                #32;
            end
            // a released line shows the inverse so a stale sample cannot match
            dat = ~dat;
        end
    endtask
endmodule // pcsp_highway_model

// *** verification/test_pcsp_serial_port.sv ***
`timescale 1ns/1ns
module test_pcsp_serial_port;
    reg ref_clk = 1'b0;
    reg rstn, isdnFourWireMode, longFrameMode, secondBearerSlot, txWordValid, rxWordReady;
    reg [7:0] txWord;
    reg [7:0] got;
    reg sawUnder = 1'b0;
    reg sawOver = 1'b0;
    reg [18:0] rows [0:5];
    wire txBitClock, txFrameSync, txPcmOut, txPcmOutEn, rxBitClock, rxFrameSync, rxPcmIn;
    wire linkBitClock, linkFrameSync, linkRxData, linkTxData, linkTxDataEn;
    wire txWordReady, txUnderrun, rxWordValid, rxOverrun;
    wire [7:0] rxWord;
    integer nFail = 0;
    integer checkCount = 0;
    integer cycles = 0;
    integer i;

    pcsp_serial_port dut (.ref_clk, .rstn, .isdnFourWireMode, .longFrameMode, .secondBearerSlot,
        .txBitClock, .txFrameSync, .txPcmOut, .txPcmOutEn, .rxBitClock, .rxFrameSync, .rxPcmIn,
        .linkBitClock, .linkFrameSync, .linkRxData, .linkTxData, .linkTxDataEn, .txWord,
        .txWordValid, .txWordReady, .txUnderrun, .rxWord, .rxWordValid, .rxWordReady, .rxOverrun);
    pcsp_highway_model hw (.isdnFourWireMode, .longFrameMode, .secondBearerSlot, .txPcmOut,
        .txPcmOutEn, .linkTxData, .linkTxDataEn, .txBitClock, .txFrameSync, .rxBitClock,
        .rxFrameSync, .rxPcmIn, .linkBitClock, .linkFrameSync, .linkRxData);

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // sticky copies of the one-cycle pulses, plus the hang guard
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (txUnderrun === 1'b1) sawUnder <= 1'b1;
        if (rxOverrun === 1'b1) sawOver <= 1'b1;
        if (cycles == 40000) begin
            nFail = nFail + 1;
            wrap_up();
        end
    end

    task check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        begin
            checkCount = checkCount + 1;
            if (seen !== exp) begin
                nFail = nFail + 1;
                $display("wrong value %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask

    // mode pins need several edges through the synchroniser before a frame
    task set_mode(input [2:0] m);
        begin
            {isdnFourWireMode, longFrameMode, secondBearerSlot} <= m;
            repeat (6) @(posedge ref_clk);
        end
    endtask

    task send(input [7:0] w);
        integer n;
        begin
            txWord <= w;
            txWordValid <= 1'b1;
            n = 0;
            @(posedge ref_clk);
            while (txWordReady !== 1'b1 && n < 50) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            txWordValid <= 1'b0;
            check("txWordReady", txWordReady, 8'h01);
        end
    endtask

    // the extra edge lets the pop land before the next look at the fifo
    task pop(input [7:0] exp);
        integer n;
        begin
            n = 0;
            while (rxWordValid !== 1'b1 && n < 50) begin
                @(posedge ref_clk);
                n = n + 1;
            end
            check("rxWordValid", rxWordValid, 8'h01);
            check("rxWord", rxWord, exp);
            rxWordReady <= 1'b1;
            @(posedge ref_clk);
            rxWordReady <= 1'b0;
            @(posedge ref_clk);
        end
    endtask

    task run_frame(input [7:0] rxw, input [7:0] txExp);
        begin
            hw.frame(rxw, got);
            check("txPcmWord", got, txExp);
            repeat (6) @(posedge ref_clk);
            check("txPcmOutEn", txPcmOutEn, 8'h00);
            check("linkTxDataEn", linkTxDataEn, 8'h00);
        end
    endtask

    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", checkCount, nFail);
            if (nFail == 0 && checkCount > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    initial begin
        {rstn, isdnFourWireMode, longFrameMode, secondBearerSlot} = 4'h0;
        {txWordValid, rxWordReady, txWord} = 10'h000;
        // link, long, second slot, tx word, rx word
        rows[0] = {3'b000, 8'ha5, 8'h3c};
        rows[1] = {3'b000, 8'h80, 8'h01};
        rows[2] = {3'b010, 8'h5a, 8'hc3};
        rows[3] = {3'b010, 8'h01, 8'h80};
        rows[4] = {3'b100, 8'h96, 8'h69};
        rows[5] = {3'b101, 8'h7e, 8'he7};
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        for (i = 0; i < 6; i = i + 1) begin
            set_mode(rows[i][18:16]);
            send(rows[i][15:8]);
            @(posedge ref_clk);
            check("txWordReady", txWordReady, 8'h00);
            run_frame(rows[i][7:0], rows[i][15:8]);
            pop(rows[i][7:0]);
        end
        // every row held a word, so no slot may have gone out empty yet
        check("txUnderrun", sawUnder, 8'h00);
        // nothing held: idle code goes out; reader stalls so words pile up
        set_mode(3'b000);
        run_frame(8'h11, 8'hff);
        check("txUnderrun", sawUnder, 8'h01);
        run_frame(8'h22, 8'hff);
        run_frame(8'h33, 8'hff);
        check("rxOverrun", sawOver, 8'h00);
        run_frame(8'h44, 8'hff);
        check("rxOverrun", sawOver, 8'h01);
        pop(8'h11);
        pop(8'h22);
        pop(8'h33);
        check("rxWordValid", rxWordValid, 8'h00);
        // reset mid-run drops a held word; the next frame carries the new one
        send(8'h42);
        rstn <= 1'b0;
        @(posedge ref_clk);
        check("txWordReady", txWordReady, 8'h00);
        check("txPcmOutEn", txPcmOutEn, 8'h00);
        rstn <= 1'b1;
        repeat (6) @(posedge ref_clk);
        check("txWordReady", txWordReady, 8'h01);
        send(8'h81);
        run_frame(8'h5a, 8'h81);
        pop(8'h5a);
        wrap_up();
    end
endmodule // test_pcsp_serial_port
